// ### src/igl_pkg.sv
// Package of shared constants for the input gating latch.
package igl_pkg;

    // =====================================================================
    // Sizes
    // =====================================================================

    // Number of gateable input pins in the default build.
    localparam int unsigned NUM_PINS = 8;

    // =====================================================================
    // Values after reset
    // =====================================================================

    // Synchroniser stages and held data clear to low.
    localparam logic RST_LEVEL = 1'h0;

    // The shared gate pin is released (not driven) while in reset.
    localparam logic RST_PIN_OE_N = 1'h1;

    // Gating is off until the rail is seen high.
    localparam logic RST_GATE = 1'h0;

    // =====================================================================
    // Cycle counts
    // =====================================================================

    // Flip-flops that a pin input passes before any logic reads it.
    localparam int unsigned SYNC_STAGES = 2;

    // Least number of reset edges so that the straps reach the capture flops.
    localparam int unsigned RST_MIN_EDGES = 3;

endpackage

// ### src/igl_gate_if.sv
// Interface that joins the gate rail control to the per-pin hold stage.
`timescale 1ns/1ps
`default_nettype none

interface igl_gate_if #(
    parameter int unsigned N = igl_pkg::NUM_PINS
);
    // Gate rail, active high, already synchronised.
    logic         gate;
    // Per-pin gating selection held since configuration.
    logic [N-1:0] sel;
    // Live pin values after synchronisation.
    logic [N-1:0] live;
    // Values presented to internal logic.
    logic [N-1:0] data;

    modport ctrl (output gate, output sel, output live, input data);
    modport hold (input gate, input sel, input live, output data);
endinterface

`default_nettype wire

// ### src/igl_hold.sv
// Per-pin hold stage: passes live values or keeps the last pre-gate value.
`timescale 1ns/1ps
`default_nettype none

module igl_hold #(
    parameter int unsigned N = igl_pkg::NUM_PINS
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rstn,
    // Gate carrier.
    igl_gate_if.hold  gif
);

    logic [N-1:0] held_reg;
    logic [N-1:0] held_next;
    logic [N-1:0] data_reg;
    logic [N-1:0] data_next;
    logic [N-1:0] block_mask;

    // Only selected pins are blocked, and only while the rail is high.
    assign block_mask = gif.sel & {N{gif.gate}};
    // The hold value follows the pin until the rail rises, then freezes.
    assign held_next  = gif.gate ? held_reg : gif.live; // R02
    // Blocked pins see the frozen value, others pass straight on.
    assign data_next  = (held_reg & block_mask) | (gif.live & ~block_mask); // R01
    assign gif.data   = data_reg;

    // Hold and output registers; the hold register never reloads while gated,
    // so toggling on a selected pin does not reach the output net.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            held_reg <= {N{igl_pkg::RST_LEVEL}};
            data_reg <= {N{igl_pkg::RST_LEVEL}};
        end else begin
            held_reg <= held_next;
            data_reg <= data_next; // R03 R06
        end
    end

    // =====================================================================
    // Checks
    // =====================================================================

    sequence s_gate_rise;
        !gif.gate ##1 gif.gate;
    endsequence

    property p_gated_stable;
        @(posedge clk) disable iff (!rstn)
        (gif.gate && $past(gif.gate)) |=> (((gif.data ^ $past(gif.data)) & gif.sel) == '0);
    endproperty
    a_gated_stable: assert property (p_gated_stable) // R01
        else $error("Gated pin changed while the rail was high.");

    property p_capture;
        @(posedge clk) disable iff (!rstn)
        s_gate_rise |=> ((gif.data & gif.sel) == ($past(gif.live, 2) & gif.sel));
    endproperty
    a_capture: assert property (p_capture) // R02
        else $error("Held value is not the last value before the rail rose.");

    property p_unselected_pass;
        @(posedge clk) disable iff (!rstn)
        $past(rstn) |=> ((gif.data & ~gif.sel) == ($past(gif.live) & ~gif.sel));
    endproperty
    a_unselected_pass: assert property (p_unselected_pass) // R03
        else $error("An unselected pin was blocked.");

    property p_release;
        @(posedge clk) disable iff (!rstn)
        !gif.gate |=> (gif.data == $past(gif.live));
    endproperty
    a_release: assert property (p_release) // R06
        else $error("Pins did not pass live values with the rail low.");

endmodule

`default_nettype wire

// ### src/igl_top.sv
// Top of the input gating latch: pin synchronisers, gate rail, shared gate pin.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R01: While the gate rail is high, toggling on a selected input does not reach the output.
// R02: On the rail rising, each selected input keeps the value seen just before and holds it.
// R03: Gating is chosen per pin at configuration, and unselected pins always pass through.
// R04: The gate rail can be driven from the outside pin or from internal logic.
// R05: Internal gate control leaves through the one shared gate pin and is read back from it.
// R06: The rail is active high, and with it low every selected pin passes its live value.
module igl_top #(
    parameter int unsigned N = igl_pkg::NUM_PINS
) (
    // Clock and reset.
    input  wire logic         CLK_SYS,
    input  wire logic         RSTN,
    // Gateable data pins.
    input  wire logic [N-1:0] DATA_PIN_IN,
    // Configuration straps, captured while reset is held.
    input  wire logic [N-1:0] GATE_SELECT_CFG,
    input  wire logic         GATE_INTERNAL_CFG,
    // Gate request from internal logic on CLK_SYS.
    input  wire logic         GATE_INTERNAL_REQ,
    // Shared dual-purpose gate pin.
    input  wire logic         INPUT_GATE_ENABLE_PIN_I,
    output var  logic         INPUT_GATE_ENABLE_PIN_O,
    output var  logic         INPUT_GATE_ENABLE_PIN_OE_N,
    // Values for internal logic.
    output var  logic [N-1:0] DATA_OUT,
    output var  logic         GATE_ACTIVE
);

    // =====================================================================
    // Declarations
    // =====================================================================

    logic [N-1:0] data_s1_reg;
    logic [N-1:0] data_s2_reg;
    logic [N-1:0] sel_s1_reg;
    logic [N-1:0] sel_s2_reg;
    logic [N-1:0] sel_reg;
    logic [N-1:0] sel_next;
    logic         int_s1_reg;
    logic         int_s2_reg;
    logic         int_reg;
    logic         int_next;
    logic         gate_s1_reg;
    logic         gate_s2_reg;
    logic         gate_active_reg;
    logic         pin_o_reg;
    logic         pin_o_next;
    logic         pin_oe_n_reg;
    logic         pin_oe_n_next;

    igl_gate_if #(.N(N)) gif ();

    // =====================================================================
    // Configuration capture
    // =====================================================================

    // Straps are synchronised, then frozen at the release of reset. Catching
    // them while reset is low avoids loading a port under reset itself and
    // keeps the selection constant for the whole run.
    assign sel_next = RSTN ? sel_reg : sel_s2_reg; // R03
    assign int_next = RSTN ? int_reg : int_s2_reg;

    always_ff @(posedge CLK_SYS) begin
        sel_s1_reg <= GATE_SELECT_CFG;
        sel_s2_reg <= sel_s1_reg;
        int_s1_reg <= GATE_INTERNAL_CFG;
        int_s2_reg <= int_s1_reg;
    end

    always_ff @(posedge CLK_SYS) begin
        sel_reg <= sel_next;
        int_reg <= int_next;
    end

    // =====================================================================
    // Shared gate pin
    // =====================================================================

    // With internal control chosen the device drives the shared pin itself;
    // otherwise the pin is left to the board. There is no second path into
    // the rail, so both sources meet the same input buffer.
    assign pin_o_next    = int_reg & GATE_INTERNAL_REQ; // R05
    assign pin_oe_n_next = ~int_reg; // R04

    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            pin_o_reg    <= igl_pkg::RST_LEVEL;
            pin_oe_n_reg <= igl_pkg::RST_PIN_OE_N;
        end else begin
            pin_o_reg    <= pin_o_next;
            pin_oe_n_reg <= pin_oe_n_next;
        end
    end

    assign INPUT_GATE_ENABLE_PIN_O    = pin_o_reg;
    assign INPUT_GATE_ENABLE_PIN_OE_N = pin_oe_n_reg;

    // =====================================================================
    // Pin synchronisers and gate rail
    // =====================================================================

    // Data and rail pass the same two stages, so the rail edge and the data
    // it gates stay aligned; a pin change less than a cycle before the rail
    // may still land on either side of the capture.
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            data_s1_reg <= {N{igl_pkg::RST_LEVEL}};
            data_s2_reg <= {N{igl_pkg::RST_LEVEL}};
            gate_s1_reg <= igl_pkg::RST_GATE;
            gate_s2_reg <= igl_pkg::RST_GATE;
        end else begin
            data_s1_reg <= DATA_PIN_IN;
            data_s2_reg <= data_s1_reg;
            gate_s1_reg <= INPUT_GATE_ENABLE_PIN_I; // R04
            gate_s2_reg <= gate_s1_reg;
        end
    end

    // Rail status, aligned with the data output.
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            gate_active_reg <= igl_pkg::RST_GATE;
        end else begin
            gate_active_reg <= gate_s2_reg; // R06
        end
    end

    assign GATE_ACTIVE = gate_active_reg;

    // =====================================================================
    // Hold stage
    // =====================================================================

    assign gif.gate = gate_s2_reg;
    assign gif.sel  = sel_reg;
    assign gif.live = data_s2_reg;

    igl_hold #(
        .N    (N)
    ) u_hold (
        .clk  (CLK_SYS),
        .rstn (RSTN),
        .gif  (gif)
    );

    assign DATA_OUT = gif.data;

    // =====================================================================
    // Checks
    // =====================================================================

    sequence s_run;
        RSTN ##1 RSTN ##1 RSTN;
    endsequence

    property p_rail_from_pin;
        @(posedge CLK_SYS) disable iff (!RSTN)
        s_run |=> (GATE_ACTIVE == $past(INPUT_GATE_ENABLE_PIN_I, 3));
    endproperty
    a_rail_from_pin: assert property (p_rail_from_pin) // R04
        else $error("Gate status does not follow the shared pin.");

    property p_internal_drive;
        @(posedge CLK_SYS) disable iff (!RSTN)
        int_reg |=> (!INPUT_GATE_ENABLE_PIN_OE_N
                     && (INPUT_GATE_ENABLE_PIN_O == $past(GATE_INTERNAL_REQ)));
    endproperty
    a_internal_drive: assert property (p_internal_drive) // R05
        else $error("Internal gate request is not driven onto the shared pin.");

    property p_external_release;
        @(posedge CLK_SYS) disable iff (!RSTN)
        !int_reg |=> INPUT_GATE_ENABLE_PIN_OE_N;
    endproperty
    a_external_release: assert property (p_external_release) // R04
        else $error("Shared pin driven although external control is chosen.");

    property p_sel_frozen;
        @(posedge CLK_SYS) disable iff (!RSTN)
        $past(RSTN) |-> ($stable(sel_reg) && $stable(int_reg));
    endproperty
    a_sel_frozen: assert property (p_sel_frozen) // R03
        else $error("Gating selection changed outside reset.");

    // Reset clears DATA_OUT, GATE_ACTIVE and the pin output, and sets the enable high to leave the shared pin to the board.
    property p_reset_state;
        @(posedge CLK_SYS)
        !RSTN |=> (INPUT_GATE_ENABLE_PIN_OE_N && !INPUT_GATE_ENABLE_PIN_O
                   && !GATE_ACTIVE && (DATA_OUT == '0));
    endproperty
    a_reset_state: assert property (p_reset_state) // R04
        else $error("Outputs are not at their reset values while reset is held.");

    // Two samples in a row with the rail seen high at the outputs.
    sequence s_gated_pair;
        GATE_ACTIVE ##1 GATE_ACTIVE;
    endsequence

    property p_selected_frozen;
        @(posedge CLK_SYS) disable iff (!RSTN)
        s_gated_pair |-> (((DATA_OUT ^ $past(DATA_OUT)) & sel_reg) == '0);
    endproperty
    a_selected_frozen: assert property (p_selected_frozen) // R01
        else $error("A selected output moved while the rail was high.");

    // Unselected pins reach the output three edges after they are sampled.
    property p_unselected_live;
        @(posedge CLK_SYS) disable iff (!RSTN)
        s_run |=> ((DATA_OUT & ~sel_reg) == ($past(DATA_PIN_IN, 3) & ~sel_reg));
    endproperty
    a_unselected_live: assert property (p_unselected_live) // R03
        else $error("An unselected pin did not reach the output in time.");

    // With the rail low at the hold stage every pin passes its live value.
    property p_open_live;
        @(posedge CLK_SYS) disable iff (!RSTN)
        (s_run ##0 !gate_s2_reg) |=> (DATA_OUT == $past(DATA_PIN_IN, 3));
    endproperty
    a_open_live: assert property (p_open_live) // R06
        else $error("A pin did not pass its live value with the rail low.");

endmodule

`default_nettype wire

// ### test/igl_board.sv
// Board model that resolves the shared gate pin between the device and an outside source.
`timescale 1ns/1ps
`default_nettype none

module igl_board (
    // Device side of the shared pin.
    input  wire logic pin_o,
    input  wire logic pin_oe_n,
    // Outside gate source on the board.
    input  wire logic ext_gate,
    // Level seen on the wire.
    output logic      pin_level
);
    // =====================================================================
    // Wire resolution
    // =====================================================================
    // The outside source backs off while the device drives, so the pin never fights.
    assign pin_level = pin_oe_n ? ext_gate : pin_o;
endmodule

`default_nettype wire

// ### test/igl_top_tb.sv
// Self-checking testbench for the input gating latch top.
`timescale 1ns/1ps
`default_nettype none

module igl_top_tb;
    // =====================================================================
    // Signals
    // =====================================================================
    localparam int unsigned NP = igl_pkg::NUM_PINS;
    localparam logic [NP-1:0] SEL = 8'hA5;
    localparam logic [NP-1:0] VAL_A = 8'h3C;
    localparam logic [NP-1:0] VAL_B = 8'hC3;
    logic          clk_sys = 1'b0;
    logic          rstn = 1'b0;
    logic [NP-1:0] data_pin = '0;
    logic [NP-1:0] sel_cfg = SEL;
    logic          int_cfg = 1'b0;
    logic          int_req = 1'b0;
    logic          ext_gate = 1'b0;
    logic          pin_level;
    logic          pin_o;
    logic          pin_oe_n;
    logic [NP-1:0] data_out;
    logic          gate_active;
    int            bad_count = 0;
    int            total_checks = 0;

    // Clock at 100 MHz.
    always #5 clk_sys = ~clk_sys;

    igl_top #(.N(NP)) dut (
        .CLK_SYS                    (clk_sys),
        .RSTN                       (rstn),
        .DATA_PIN_IN                (data_pin),
        .GATE_SELECT_CFG            (sel_cfg),
        .GATE_INTERNAL_CFG          (int_cfg),
        .GATE_INTERNAL_REQ          (int_req),
        .INPUT_GATE_ENABLE_PIN_I    (pin_level),
        .INPUT_GATE_ENABLE_PIN_O    (pin_o),
        .INPUT_GATE_ENABLE_PIN_OE_N (pin_oe_n),
        .DATA_OUT                   (data_out),
        .GATE_ACTIVE                (gate_active)
    );

    igl_board board (
        .pin_o     (pin_o),
        .pin_oe_n  (pin_oe_n),
        .ext_gate  (ext_gate),
        .pin_level (pin_level)
    );

    // =====================================================================
    // Helpers
    // =====================================================================
    // Compare one value against its expectation and count it.
    task automatic check(input logic [NP-1:0] seen, input logic [NP-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Let n edges pass, then sample at the falling edge where outputs are settled.
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // Reset for six cycles with the straps held, since they freeze at release.
    task automatic do_reset(input logic internal);
        @(posedge clk_sys);
        rstn <= 1'b0;
        int_cfg <= internal;
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        @(negedge clk_sys);
    endtask

    // Print the counts and the verdict, then end the run.
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // =====================================================================
    // Scenarios
    // =====================================================================
    // Outside gate: selected bits hold the pre-gate value, others keep passing.
    // An internal request is raised too, and must not reach the pin in this mode.
    task automatic t_outside_gate;
        @(posedge clk_sys);
        int_req <= 1'b1;
        settle(1);
        check(NP'(pin_oe_n), NP'(1'b1));
        check(NP'(pin_o), NP'(1'b0));
        @(posedge clk_sys);
        data_pin <= VAL_A;
        settle(4);
        check(data_out, VAL_A);
        @(posedge clk_sys);
        ext_gate <= 1'b1;
        settle(4);
        check(NP'(gate_active), NP'(1'b1));
        @(posedge clk_sys);
        data_pin <= VAL_B;
        repeat (2) @(posedge clk_sys);
        data_pin <= VAL_A;
        @(posedge clk_sys);
        data_pin <= VAL_B;
        settle(4);
        check(data_out, (VAL_A & SEL) | (VAL_B & ~SEL));
        @(posedge clk_sys);
        ext_gate <= 1'b0;
        int_req <= 1'b0;
        settle(4);
        check(NP'(gate_active), NP'(1'b0));
        check(data_out, VAL_B);
        $display("test outside gate done");
    endtask

    // Internal gate: device drives the shared pin and the board source is ignored.
    task automatic t_internal_gate;
        do_reset(1'b1);
        settle(1);
        check(NP'(pin_oe_n), NP'(1'b0));
        @(posedge clk_sys);
        data_pin <= VAL_A;
        ext_gate <= 1'b1;
        settle(5);
        check(NP'(gate_active), NP'(1'b0));
        check(data_out, VAL_A);
        @(posedge clk_sys);
        int_req <= 1'b1;
        settle(5);
        check(NP'(pin_o), NP'(1'b1));
        check(NP'(gate_active), NP'(1'b1));
        @(posedge clk_sys);
        data_pin <= VAL_B;
        settle(4);
        check(data_out, (VAL_A & SEL) | (VAL_B & ~SEL));
        @(posedge clk_sys);
        int_req <= 1'b0;
        settle(5);
        check(NP'(pin_o), NP'(1'b0));
        check(data_out, VAL_B);
        $display("test internal gate done");
    endtask

    // =====================================================================
    // Main sequence and watchdog
    // =====================================================================
    // Main sequence of scenarios.
    initial begin
        do_reset(1'b0);
        t_outside_gate();
        t_internal_gate();
        report_and_stop();
    end

    // The tests need about 63 cycles; a hang is cut off well past that.
    initial begin
        repeat (2000) @(posedge clk_sys);
        bad_count++;
        report_and_stop();
    end
endmodule

`default_nettype wire
